/* rtl/clc_cursor_chan.v */
`timescale 1ns/1ps
`include "clc_cursor_map.vh"

module clc_cursor_chan (
   input wire i_core_clk,
   input wire i_rst_b,
   input wire [31:0] i_s_axi_awaddr,
   input wire i_s_axi_awvalid,
   output wire o_s_axi_awready,
   input wire [31:0] i_s_axi_wdata,
   input wire [3:0] i_s_axi_wstrb,
   input wire i_s_axi_wvalid,
   output wire o_s_axi_wready,
   output wire [1:0] o_s_axi_bresp,
   output wire o_s_axi_bvalid,
   input wire i_s_axi_bready,
   input wire [31:0] i_s_axi_araddr,
   input wire i_s_axi_arvalid,
   output wire o_s_axi_arready,
   output wire [31:0] o_s_axi_rdata,
   output wire [1:0] o_s_axi_rresp,
   output wire o_s_axi_rvalid,
   input wire i_s_axi_rready,
   input wire i_sof,
   input wire i_eof,
   input wire i_head_taken,
   input wire i_evt_xfer_done,
   input wire i_evt_desc_loaded,
   input wire i_evt_head_loaded,
   input wire i_evt_list_end,
   input wire i_evt_overflow,
   output wire o_channel_enable,
   output wire o_attr_apply,
   output wire o_channel_abort,
   output wire o_queue_head_request,
   output wire [31:0] o_head_ptr,
   output wire o_irq
);

   // One-hot channel states. The enable then ORs just two state bits, so
   // it never waits on a wide compare.
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_RUN = 3'h2;
   localparam [2:0] ST_STOP = 3'h4;

   // True when a bus address selects the word at the given offset.
   // Bits 1:0 are ignored, so any byte address inside a word selects it.
   function clc_hit;
      input [31:0] addr;
      input [31:0] offs;
      begin
         clc_hit = (addr[31:2] == offs[31:2]);
      end
   endfunction

   // True when the address selects any mapped register.
   // Anything else is answered with an error rather than dropped quietly.
   function clc_mapped;
      input [31:0] addr;
      begin
         clc_mapped = clc_hit(addr, `CLC_ADDR_CH_SET) ||
            clc_hit(addr, `CLC_ADDR_CH_CLEAR) ||
            clc_hit(addr, `CLC_ADDR_CH_STATE) ||
            clc_hit(addr, `CLC_ADDR_IRQ_SET) ||
            clc_hit(addr, `CLC_ADDR_IRQ_CLEAR) ||
            clc_hit(addr, `CLC_ADDR_IRQ_MASK) ||
            clc_hit(addr, `CLC_ADDR_IRQ_FLAGS) ||
            clc_hit(addr, `CLC_ADDR_HEAD);
      end
   endfunction

   // Bus side state. Each write half has a slot of its own, so address
   // and data may come in either order without any further buffer.
   reg aw_full_reg;
   reg [31:0] aw_addr_reg;
   reg w_full_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0] rresp_reg;

   // Channel side state.
   reg [2:0] ch_state_reg;
   reg [2:0] ch_state_next;
   reg attr_pending_reg;
   reg attr_pending_next;
   reg queue_pending_reg;
   reg queue_pending_next;
   reg attr_apply_reg;
   reg abort_reg;
   reg [31:0] head_reg;
   reg [31:0] head_next;
   reg [31:0] mask_reg;
   reg [31:0] mask_next;
   reg [31:0] flags_reg;
   reg [31:0] flags_next;
   reg [31:0] rd_value;

   wire aw_take;
   wire w_take;
   wire ar_take;
   wire do_write;
   wire lane0;
   wire lane1;
   wire wr_start;
   wire wr_attr;
   wire wr_queue;
   wire wr_stop;
   wire wr_abort;
   wire wr_irq_set;
   wire wr_irq_clr;
   wire wr_head;
   wire rd_flags;
   wire channel_on;
   reg [31:0] evt_vec;
   wire [31:0] rd_clear;
   wire [31:0] head_bytes;

   // Address and data are held apart, so they may arrive in any order.
   // A pending response blocks both halves; this keeps one write in flight
   // and means its effect is never applied twice.
   assign o_s_axi_awready = !aw_full_reg && !bvalid_reg;
   assign o_s_axi_wready = !w_full_reg && !bvalid_reg;
   assign aw_take = i_s_axi_awvalid && o_s_axi_awready;
   assign w_take = i_s_axi_wvalid && o_s_axi_wready;
   assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
   assign o_s_axi_bvalid = bvalid_reg;
   assign o_s_axi_bresp = bresp_reg;

   // A read is accepted only while no answer is waiting.
   // Data is captured at the taking edge and stands unchanged until rready.
   assign o_s_axi_arready = !rvalid_reg;
   assign ar_take = i_s_axi_arvalid && o_s_axi_arready;
   assign o_s_axi_rvalid = rvalid_reg;
   assign o_s_axi_rdata = rdata_reg;
   assign o_s_axi_rresp = rresp_reg;

   // Write strobes of the control registers, honouring byte lanes.
   // Every control bit sits in byte lane zero except the abort bit in lane
   // one; a write that leaves a lane out leaves those bits alone.
   assign lane0 = w_strb_reg[0];
   assign lane1 = w_strb_reg[1];
   assign wr_start = do_write && clc_hit(aw_addr_reg, `CLC_ADDR_CH_SET) &&
      lane0 && w_data_reg[`CLC_BIT_START];
   assign wr_attr = do_write && clc_hit(aw_addr_reg, `CLC_ADDR_CH_SET) &&
      lane0 && w_data_reg[`CLC_BIT_ATTR];
   assign wr_queue = do_write && clc_hit(aw_addr_reg, `CLC_ADDR_CH_SET) &&
      lane0 && w_data_reg[`CLC_BIT_QUEUE];
   assign wr_stop = do_write && clc_hit(aw_addr_reg, `CLC_ADDR_CH_CLEAR) &&
      lane0 && w_data_reg[`CLC_BIT_STOP];
   assign wr_abort = do_write &&
      clc_hit(aw_addr_reg, `CLC_ADDR_CH_CLEAR) &&
      lane1 && w_data_reg[`CLC_BIT_ABORT];
   assign wr_irq_set = do_write && clc_hit(aw_addr_reg, `CLC_ADDR_IRQ_SET) &&
      lane0;
   assign wr_irq_clr = do_write &&
      clc_hit(aw_addr_reg, `CLC_ADDR_IRQ_CLEAR) && lane0;
   assign wr_head = do_write && clc_hit(aw_addr_reg, `CLC_ADDR_HEAD);
   assign rd_flags = ar_take && clc_hit(i_s_axi_araddr, `CLC_ADDR_IRQ_FLAGS);

   // Gather the datapath events into the flag layout. Each event is placed
   // by its named position, so flags, mask, set and clear stay in step.
   always @* begin
      evt_vec = `CLC_RESET_VAL;
      evt_vec[`CLC_IRQ_XFER] = i_evt_xfer_done;
      evt_vec[`CLC_IRQ_DESC] = i_evt_desc_loaded;
      evt_vec[`CLC_IRQ_HEAD] = i_evt_head_loaded;
      evt_vec[`CLC_IRQ_LIST] = i_evt_list_end;
      evt_vec[`CLC_IRQ_OVERFLOW] = i_evt_overflow;
   end

   // Only the flag bits that exist are cleared by a read of the flags.
   assign rd_clear = rd_flags ? `CLC_IRQ_FIELD : `CLC_RESET_VAL;

   // Byte-lane merge for the head pointer.
   // Bits 1:0 are dropped afterwards, since descriptors are word aligned.
   assign head_bytes = {
      w_strb_reg[3] ? w_data_reg[31:24] : head_reg[31:24],
      w_strb_reg[2] ? w_data_reg[23:16] : head_reg[23:16],
      w_strb_reg[1] ? w_data_reg[15:8] : head_reg[15:8],
      w_strb_reg[0] ? w_data_reg[7:0] : head_reg[7:0]};

   // Both run and stopping count as enabled until the frame closes.
   // Software sees the channel busy for as long as a frame may still run.
   assign channel_on = ch_state_reg[1] || ch_state_reg[2];

   // Outputs. The interrupt is a level built from registers only, so it
   // carries no glitch from the bus decode.
   assign o_channel_enable = channel_on;
   assign o_attr_apply = attr_apply_reg;
   assign o_channel_abort = abort_reg;
   assign o_queue_head_request = queue_pending_reg;
   assign o_head_ptr = head_reg;
   assign o_irq = |(flags_reg & mask_reg);

   // Bus write path: capture address and data, answer once both are in.
   // The response code is judged from the held address, as the master may
   // already have moved the live bus on.
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= `CLC_RESET_VAL;
         w_full_reg <= 1'b0;
         w_data_reg <= `CLC_RESET_VAL;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `CLC_RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= i_s_axi_awaddr;
         end
         if (w_take) begin
            w_full_reg <= 1'b1;
            w_data_reg <= i_s_axi_wdata;
            w_strb_reg <= i_s_axi_wstrb;
         end
         if (do_write) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            if (clc_mapped(aw_addr_reg)) begin
               bresp_reg <= `CLC_RESP_OKAY;
            end else begin
               bresp_reg <= `CLC_RESP_SLVERR;
            end
         end else if (bvalid_reg && i_s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Read multiplexer; write-only registers read as zero.
   // The flags read returns the value before the clear, so no event that
   // software has not seen is thrown away.
   always @* begin
      rd_value = `CLC_RESET_VAL;
      if (clc_hit(i_s_axi_araddr, `CLC_ADDR_CH_STATE)) begin
         rd_value[`CLC_BIT_START] = channel_on;
         rd_value[`CLC_BIT_ATTR] = attr_pending_reg;
         rd_value[`CLC_BIT_QUEUE] = queue_pending_reg;
      end else if (clc_hit(i_s_axi_araddr, `CLC_ADDR_IRQ_MASK)) begin
         rd_value = mask_reg;
      end else if (clc_hit(i_s_axi_araddr, `CLC_ADDR_IRQ_FLAGS)) begin
         rd_value = flags_reg;
      end else if (clc_hit(i_s_axi_araddr, `CLC_ADDR_HEAD)) begin
         rd_value = head_reg;
      end
   end

   // Bus read path: one registered answer, held until rready.
   // Only one read is in flight; arready stays low while the answer waits.
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= `CLC_RESET_VAL;
         rresp_reg <= `CLC_RESP_OKAY;
      end else begin
         if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_value;
            if (clc_mapped(i_s_axi_araddr)) begin
               rresp_reg <= `CLC_RESP_OKAY;
            end else begin
               rresp_reg <= `CLC_RESP_SLVERR;
            end
         end else if (rvalid_reg && i_s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // Channel state machine. An abort wins over everything, since it
   // must drop the frame at once; a start while stopping cancels the stop.
   // A stop written in the cycle of a frame end acts at once, since that
   // frame is already complete.
   always @* begin
      ch_state_next = ch_state_reg;
      case (ch_state_reg)
         ST_IDLE: begin
            if (wr_start) begin
               ch_state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (wr_stop && i_eof) begin
               ch_state_next = ST_IDLE;
            end else if (wr_stop) begin
               ch_state_next = ST_STOP;
            end
         end
         ST_STOP: begin
            if (wr_start) begin
               ch_state_next = ST_RUN;
            end else if (i_eof) begin
               ch_state_next = ST_IDLE;
            end
         end
         default: begin
            ch_state_next = ST_IDLE;
         end
      endcase
      if (wr_abort) begin
         ch_state_next = ST_IDLE;
      end
   end

   // Pending requests. A new request in the cycle that retires the old
   // one survives, so a late write is never lost.
   // An abort clears both, so nothing stale is applied after a restart.
   always @* begin
      attr_pending_next = (attr_pending_reg && !i_sof) || wr_attr;
      queue_pending_next =
         (queue_pending_reg && !i_head_taken) || wr_queue;
      if (wr_abort) begin
         attr_pending_next = 1'b0;
         queue_pending_next = 1'b0;
      end
   end

   // Head pointer, mask and flags next values.
   // Set and clear of the mask sit at separate addresses, so one write can
   // never ask for both.
   always @* begin
      head_next = head_reg;
      if (wr_head) begin
         head_next = head_bytes & `CLC_HEAD_FIELD;
      end
      mask_next = mask_reg;
      if (wr_irq_set) begin
         mask_next = mask_reg | (w_data_reg & `CLC_IRQ_FIELD);
      end else if (wr_irq_clr) begin
         mask_next = mask_reg & ~(w_data_reg & `CLC_IRQ_FIELD);
      end
      // The read returns the old flags; an event in that cycle is kept.
      flags_next = (flags_reg & ~rd_clear) | evt_vec;
   end

   // Channel registers. The apply pulse is held back by an abort in the
   // same cycle, so an abandoned frame never takes new attributes.
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ch_state_reg <= ST_IDLE;
         attr_pending_reg <= 1'b0;
         queue_pending_reg <= 1'b0;
         attr_apply_reg <= 1'b0;
         abort_reg <= 1'b0;
         head_reg <= `CLC_RESET_VAL;
      end else begin
         ch_state_reg <= ch_state_next;
         attr_pending_reg <= attr_pending_next;
         queue_pending_reg <= queue_pending_next;
         attr_apply_reg <= i_sof && attr_pending_reg && !wr_abort;
         abort_reg <= wr_abort;
         head_reg <= head_next;
      end
   end

   // Interrupt registers. Event inputs come from the fetch logic on this
   // clock, so they need no synchroniser.
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mask_reg <= `CLC_RESET_VAL;
         flags_reg <= `CLC_RESET_VAL;
      end else begin
         mask_reg <= mask_next;
         // Flag bits are set from evt_vec.
         flags_reg <= flags_next;
      end
   end

endmodule

/* rtl/clc_cursor_map.vh */
// Operation
// - Writing one to set bit 0 starts the cursor channel; zero does nothing.
// - Set bit 1 schedules window attributes for the next frame start.
// - Set bit 2 queues the head pointer; hardware clears it once added.
// - Clear bit 0 stops the channel only after the current frame ends.
// - Clear bit 8 resets the channel at once, abandoning the frame.
// - State bit 0 reports whether the channel is enabled.
// - State bit 1 reads one while an attribute refresh is pending.
// - State bit 2 reads one while the head pointer is not yet queued.
// - Writing ones to the irq set register enables those sources.
// - Writing ones to the irq clear register disables those sources.
// - The mask register reads one for every enabled source.
// - End of transfer sets the transfer-done flag.
// - A fetched descriptor sets the descriptor-loaded flag.
// - A fetched head descriptor sets the head-loaded flag.
// - Reaching the end of the descriptor chain sets the end-of-list flag.
// - A layer overflow sets the overflow flag.
// - Reading the flags register clears every flag.
// - The head register holds the new descriptor address to queue.
`ifndef CLC_CURSOR_MAP_VH
`define CLC_CURSOR_MAP_VH

// Register byte addresses.
`define CLC_ADDR_CH_SET 32'hF8038340
`define CLC_ADDR_CH_CLEAR 32'hF8038344
`define CLC_ADDR_CH_STATE 32'hF8038348
`define CLC_ADDR_IRQ_SET 32'hF803834C
`define CLC_ADDR_IRQ_CLEAR 32'hF8038350
`define CLC_ADDR_IRQ_MASK 32'hF8038354
`define CLC_ADDR_IRQ_FLAGS 32'hF8038358
`define CLC_ADDR_HEAD 32'hF803835C

// Field positions in the channel set, clear and state registers.
`define CLC_BIT_START 0
`define CLC_BIT_ATTR 1
`define CLC_BIT_QUEUE 2
`define CLC_BIT_STOP 0
`define CLC_BIT_ABORT 8

// Interrupt source positions, shared by set, clear, mask and flags.
`define CLC_IRQ_XFER 2
`define CLC_IRQ_DESC 3
`define CLC_IRQ_HEAD 4
`define CLC_IRQ_LIST 5
`define CLC_IRQ_OVERFLOW 6
`define CLC_IRQ_FIELD 32'h0000007C

// Head pointer keeps word-aligned addresses only.
`define CLC_HEAD_FIELD 32'hFFFFFFFC

// Reset values and bus answers.
`define CLC_RESET_VAL 32'h00000000
`define CLC_RESP_OKAY 2'h0
`define CLC_RESP_SLVERR 2'h2

`endif

/* testbench/clc_cursor_chan_chk.sv */
`timescale 1ns/1ps
// Watches the channel control outputs against the strobes that cause them.
module clc_cursor_chan_chk (
   input wire i_core_clk,
   input wire i_rst_b,
   input wire i_sof,
   input wire i_eof,
   input wire i_head_taken,
   input wire o_s_axi_bvalid,
   input wire i_s_axi_bready,
   input wire o_s_axi_rvalid,
   input wire o_channel_enable,
   input wire o_attr_apply,
   input wire o_channel_abort,
   input wire o_queue_head_request,
   input wire o_irq
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_b);

   // Only a completed register write may bring the channel up.
   AST_START_BY_WRITE: assert property (
      $rose(o_channel_enable) |-> $rose(o_s_axi_bvalid))
      else $error("channel enabled without a write");
   // The apply pulse follows a frame start and lasts one cycle.
   AST_ATTR_AT_SOF: assert property (
      o_attr_apply |-> $past(i_sof) ##1 !o_attr_apply)
      else $error("attribute apply out of place");
   // A graceful stop may only land after the frame has ended.
   AST_STOP_AT_EOF: assert property (
      $fell(o_channel_enable) |-> $past(i_eof) || o_channel_abort)
      else $error("channel dropped in mid frame");
   // An abort leaves nothing running or pending.
   AST_ABORT_CLEARS: assert property (
      o_channel_abort |-> !o_channel_enable && !o_queue_head_request
      ##1 !o_channel_abort)
      else $error("abort left state behind");
   // The queue request stands until the list takes the head.
   AST_QUEUE_HOLD: assert property (
      o_queue_head_request && !i_head_taken |=>
      o_queue_head_request || o_channel_abort)
      else $error("queue request dropped early");
   AST_QUEUE_DROP: assert property (
      o_queue_head_request && i_head_taken |=> !o_queue_head_request)
      else $error("queue request not cleared");
   // Interrupt falls only through a flags read or a mask write.
   AST_IRQ_FALL: assert property (
      $fell(o_irq) |-> $rose(o_s_axi_rvalid) || $rose(o_s_axi_bvalid))
      else $error("interrupt dropped with no cause");
   AST_BRESP_DONE: assert property (
      o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
      else $error("write response not retired");

   // Main scenarios reached.
   cover property (o_attr_apply);
   cover property (o_channel_abort);
   cover property ($fell(o_irq));
endmodule

/* testbench/clc_cursor_chan_test.sv */
`timescale 1ns/1ps
`include "clc_cursor_map.vh"
// Directed bench for the cursor channel control block.
module clc_cursor_chan_test;
   logic i_core_clk = 1'h0, i_rst_b = 1'h0, i_sof = 1'h0, i_eof = 1'h0;
   logic i_head_taken = 1'h0, i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0;
   logic i_s_axi_bready = 1'h0, i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
   logic [31:0] i_s_axi_awaddr = 32'h0, i_s_axi_wdata = 32'h0;
   logic [31:0] i_s_axi_araddr = 32'h0;
   logic [3:0] i_s_axi_wstrb = 4'hF;
   logic [4:0] evt = 5'h0;
   wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
   wire o_s_axi_rvalid, o_channel_enable, o_attr_apply, o_channel_abort;
   wire o_queue_head_request, o_irq;
   wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
   wire [31:0] o_s_axi_rdata, o_head_ptr;
   int n_errors = 0, checks = 0, cycles = 0, n_abort = 0;

   clc_cursor_chan DUT (
      .i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
      .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
      .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
      .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
      .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp),
      .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
      .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
      .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
      .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
      .i_s_axi_rready(i_s_axi_rready), .i_sof(i_sof), .i_eof(i_eof),
      .i_head_taken(i_head_taken), .i_evt_xfer_done(evt[0]),
      .i_evt_desc_loaded(evt[1]), .i_evt_head_loaded(evt[2]),
      .i_evt_list_end(evt[3]), .i_evt_overflow(evt[4]),
      .o_channel_enable(o_channel_enable), .o_attr_apply(o_attr_apply),
      .o_channel_abort(o_channel_abort),
      .o_queue_head_request(o_queue_head_request),
      .o_head_ptr(o_head_ptr), .o_irq(o_irq)
   );

   // Free-running core clock, 4 ns period.
   initial begin
      forever #2 i_core_clk = ~i_core_clk;
   end

   // Cycle budget cuts a hang short; abort pulses are tallied here.
   always @(posedge i_core_clk) begin
      cycles <= cycles + 1;
      if (o_channel_abort === 1'b1) n_abort <= n_abort + 1;
      if (cycles == 4000) begin
         n_errors = n_errors + 1;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("errors %0d, checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t word %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t bit %b, expected %b", $time, got, exp);
      end
   endtask

   // Both write halves go out together; each drops once it is taken.
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                         input logic [1:0] er = `CLC_RESP_OKAY,
                         input logic [3:0] s = 4'hF);
      logic ta, tw;
      logic [1:0] r;
      @(posedge i_core_clk);
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_wstrb <= s;
      i_s_axi_awvalid <= 1'h1;
      i_s_axi_wvalid <= 1'h1;
      i_s_axi_bready <= 1'h1;
      @(negedge i_core_clk);
      while (i_s_axi_awvalid | i_s_axi_wvalid) begin
         ta = o_s_axi_awready === 1'b1;
         tw = o_s_axi_wready === 1'b1;
         @(posedge i_core_clk);
         if (ta) i_s_axi_awvalid <= 1'h0;
         if (tw) i_s_axi_wvalid <= 1'h0;
         @(negedge i_core_clk);
      end
      while (o_s_axi_bvalid !== 1'b1) @(negedge i_core_clk);
      r = o_s_axi_bresp;
      @(posedge i_core_clk);
      i_s_axi_bready <= 1'h0;
      chk_word({30'h0, r}, {30'h0, er});
      @(negedge i_core_clk);
   endtask

   task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed,
                         input logic [1:0] er = `CLC_RESP_OKAY);
      logic [31:0] d;
      logic [1:0] r;
      @(posedge i_core_clk);
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'h1;
      i_s_axi_rready <= 1'h1;
      @(negedge i_core_clk);
      while (o_s_axi_arready !== 1'b1) @(negedge i_core_clk);
      @(posedge i_core_clk);
      i_s_axi_arvalid <= 1'h0;
      @(negedge i_core_clk);
      while (o_s_axi_rvalid !== 1'b1) @(negedge i_core_clk);
      d = o_s_axi_rdata;
      r = o_s_axi_rresp;
      @(posedge i_core_clk);
      i_s_axi_rready <= 1'h0;
      chk_word(d, ed);
      chk_word({30'h0, r}, {30'h0, er});
      @(negedge i_core_clk);
   endtask

   // One-cycle strobe: 0 frame start, 1 frame end, 2 head taken, 3+ events.
   task automatic pulse(input int k);
      @(posedge i_core_clk);
      case (k)
         0: i_sof <= 1'h1;
         1: i_eof <= 1'h1;
         2: i_head_taken <= 1'h1;
         default: evt <= 5'h1 << (k - 3);
      endcase
      @(posedge i_core_clk);
      {i_sof, i_eof, i_head_taken, evt} <= 8'h0;
      @(negedge i_core_clk);
   endtask

   // Reset values, a read-only write and an unmapped address.
   task automatic t_reset();
      for (int i = 0; i < 8; i++)
         axi_rd(`CLC_ADDR_CH_SET + 4 * i, 32'h0);
      axi_wr(`CLC_ADDR_CH_STATE, 32'h7);
      axi_rd(`CLC_ADDR_CH_STATE, 32'h0);
      axi_rd(32'hF8038360, 32'h0, `CLC_RESP_SLVERR);
      axi_wr(32'hF8038360, 32'h1, `CLC_RESP_SLVERR);
   endtask

   // Start, then a stop that must wait for the frame end.
   task automatic t_chan();
      axi_wr(`CLC_ADDR_CH_SET, 32'h0);
      axi_rd(`CLC_ADDR_CH_STATE, 32'h0);
      axi_wr(`CLC_ADDR_CH_SET, 32'h1);
      axi_rd(`CLC_ADDR_CH_STATE, 32'h1);
      axi_wr(`CLC_ADDR_CH_CLEAR, 32'h1);
      axi_rd(`CLC_ADDR_CH_STATE, 32'h1);
      pulse(1);
      chk_bit(o_channel_enable, 1'h0);
      axi_rd(`CLC_ADDR_CH_STATE, 32'h0);
   endtask

   task automatic t_attr();
      axi_wr(`CLC_ADDR_CH_SET, 32'h2);
      axi_rd(`CLC_ADDR_CH_STATE, 32'h2);
      pulse(0);
      chk_bit(o_attr_apply, 1'h1);
      axi_rd(`CLC_ADDR_CH_STATE, 32'h0);
   endtask

   task automatic t_queue();
      axi_wr(`CLC_ADDR_HEAD, 32'hA5A5A5A7);
      axi_rd(`CLC_ADDR_HEAD, 32'hA5A5A5A4);
      chk_word(o_head_ptr, 32'hA5A5A5A4);
      axi_wr(`CLC_ADDR_HEAD, 32'h00000011, `CLC_RESP_OKAY, 4'h1);
      axi_rd(`CLC_ADDR_HEAD, 32'hA5A5A510);
      axi_wr(`CLC_ADDR_CH_SET, 32'h4);
      axi_rd(`CLC_ADDR_CH_STATE, 32'h4);
      chk_bit(o_queue_head_request, 1'h1);
      pulse(2);
      chk_bit(o_queue_head_request, 1'h0);
      axi_rd(`CLC_ADDR_CH_STATE, 32'h0);
   endtask

   // Abort in mid frame with everything pending.
   task automatic t_abort();
      axi_wr(`CLC_ADDR_CH_SET, 32'h7);
      axi_rd(`CLC_ADDR_CH_STATE, 32'h7);
      axi_wr(`CLC_ADDR_CH_CLEAR, 32'h100, `CLC_RESP_OKAY, 4'h1);
      axi_rd(`CLC_ADDR_CH_STATE, 32'h7);
      axi_wr(`CLC_ADDR_CH_CLEAR, 32'h100);
      axi_rd(`CLC_ADDR_CH_STATE, 32'h0);
      chk_word(n_abort, 32'h1);
   endtask

   task automatic t_irq();
      logic [31:0] m = 32'h38;
      axi_wr(`CLC_ADDR_IRQ_SET, 32'h7C);
      axi_rd(`CLC_ADDR_IRQ_MASK, 32'h7C);
      axi_wr(`CLC_ADDR_IRQ_CLEAR, 32'h44);
      axi_wr(`CLC_ADDR_IRQ_SET, 32'h0);
      axi_wr(`CLC_ADDR_IRQ_CLEAR, 32'h0);
      axi_rd(`CLC_ADDR_IRQ_MASK, m);
      for (int i = 0; i < 5; i++) begin
         pulse(i + 3);
         chk_bit(o_irq, m[i + 2]);
         axi_rd(`CLC_ADDR_IRQ_FLAGS, 32'h4 << i);
         axi_rd(`CLC_ADDR_IRQ_FLAGS, 32'h0);
      end
      pulse(7);
      axi_wr(`CLC_ADDR_IRQ_SET, 32'h40);
      chk_bit(o_irq, 1'h1);
      axi_rd(`CLC_ADDR_IRQ_FLAGS, 32'h40);
      chk_bit(o_irq, 1'h0);
   endtask

   // Reset for three cycles, then run each scenario in turn.
   initial begin
      repeat (3) @(posedge i_core_clk);
      i_rst_b <= 1'h1;
      t_reset();
      t_chan();
      t_attr();
      t_queue();
      t_abort();
      t_irq();
      stop_test();
   end
endmodule

bind clc_cursor_chan clc_cursor_chan_chk u_chk (
   .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_sof(i_sof),
   .i_eof(i_eof), .i_head_taken(i_head_taken),
   .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
   .o_s_axi_rvalid(o_s_axi_rvalid), .o_channel_enable(o_channel_enable),
   .o_attr_apply(o_attr_apply), .o_channel_abort(o_channel_abort),
   .o_queue_head_request(o_queue_head_request), .o_irq(o_irq)
);
